// *** logic/mcl_line_coh.sv ***
// What this block does
// R01 - Invalid line holds no usable data
// R02 - Exclusive: clean, no other copy
// R03 - Shared: current, others may share
// R04 - Modified: sole copy, memory stale
// R05 - Only one owner; others shared
// R06 - Missing masters probe other caches
// R07 - Supply newest data on probe hit
// R08 - Requester uses memory if unsupplied
// R09 - Read and write probes differ
// R10 - Non-caching read probe keeps state
// R11 - Local miss issues probe, memory read
// R12 - Read hit keeps state
// R13 - Write hit moves to modified
// R14 - Write miss fills exclusive then modifies; here the fill takes shared when FILL_SHARED is set, then modifies
// R15 - Aligned quadword-or-smaller access is atomic
// R16 - Misaligned inside quadword is atomic
// R17 - Locked misaligned access is atomic
// R18 - Use refreshed translation after invalidate
// R19 - Write probe hit invalidates after supply
//
// Per-line MOESI state array for a small direct-mapped cache.
// Assumes the probe partner and memory answer on single-cycle strobes.
// Requests are taken only while idle with fresh translations;
// the caller holds REQ until REQ_DONE and drops valid then.
// One miss is outstanding, so the held request names the line
// that the fill and the write after the fill will touch.
// Probes answer one cycle later, except on the index of a
// pending local access; the requester then retries.
// Limitation: one way per index, and a miss replaces the line
// without a victim writeback; that path lives outside.
// Read probes keep a copy where the requester caches;
// write probes always invalidate after any data supply.
// Uncacheable requests complete at once unless a locked one crosses a quadword; their memory
// traffic is handled outside this block.
// Reset clears every line to invalid, every output to zero.
`timescale 1ns/10ps
`default_nettype none
`include "mcl_params.svh"
module mcl_line_coh (
  // Clock and reset
  input  wire logic               REF_CLK,
  input  wire logic               NRST,
  // Local request
  input  wire mcl_pkg::mcl_req_s  REQ,
  output logic                    REQ_READY,
  output logic                    REQ_DONE,
  output logic                    REQ_ATOMIC,
  output logic [`MCL_DATA_W-1:0]  REQ_RDATA,
  // Incoming probe
  input  wire mcl_pkg::mcl_probe_s PROBE,
  output mcl_pkg::mcl_presp_s     PROBE_RSP,
  // Outgoing miss and fill
  output mcl_pkg::mcl_miss_s      MISS,
  input  wire logic               FILL_VALID,
  input  wire logic               FILL_SHARED,
  input  wire logic [`MCL_DATA_W-1:0] FILL_DATA,
  // Translation refresh
  input  wire logic               PAGE_INVALIDATE,
  input  wire logic               PAGE_BASE_WR,
  input  wire logic               WALK_DONE,
  output logic                    XLATE_STALE,
  // Line state at the request index, or at the held request's index while busy
  output mcl_pkg::mcl_state_e     LINE_STATE
);

  // Controller phases:
  //   idle  - takes local requests and probes
  //   miss  - waits for the fill
  //   split - holds the port for a locked crossing access
  //   whit  - applies the write half of a write miss
  // Controller states
  typedef enum logic [1:0] {
    MCL_IDLE  = 2'h0,
    MCL_MISS  = 2'h1,
    MCL_SPLIT = 2'h2,
    MCL_WHIT  = 2'h3
  } mcl_ctl_e;

  // Small arrays live in flip-flops, so a probe and a local
  // access can read different lines in one cycle.
  // Line storage: state, tag and data per index
  mcl_pkg::mcl_state_e          st_q   [`MCL_LINES];
  logic [`MCL_TAG_W-1:0]        tag_q  [`MCL_LINES];
  logic [`MCL_DATA_W-1:0]       dat_q  [`MCL_LINES];

  // Controller registers; besides the line arrays these are
  // the only state of the block apart from the REQ_READY flop and the stale_q flop in u_xlate.
  // Controller registers
  mcl_ctl_e                     ctl_q;
  mcl_ctl_e                     ctl_d;
  mcl_pkg::mcl_req_s            req_q;              // Held request during miss
  logic [1:0]                   split_q;            // Locked split cycle count
  logic                         req_done_q;
  logic                         req_atomic_q;
  logic [`MCL_DATA_W-1:0]       rdata_q;
  mcl_pkg::mcl_presp_s          prsp_q;
  mcl_pkg::mcl_miss_s           miss_q;
  mcl_pkg::mcl_state_e          line_q;
  logic                         stale_w;

  // Address split: byte offset low, then index, then tag.
  // The offset only matters for the quadword-fit test.
  // Index and tag extraction, used for both local and probe addresses
  function automatic logic [`MCL_IDX_W-1:0] idx_of(input logic [`MCL_ADDR_W-1:0] a);
    idx_of = a[`MCL_IDX_LO +: `MCL_IDX_W];
  endfunction : idx_of

  function automatic logic [`MCL_TAG_W-1:0] tag_of(input logic [`MCL_ADDR_W-1:0] a);
    tag_of = a[`MCL_TAG_LO +: `MCL_TAG_W];
  endfunction : tag_of

  // Offset plus size is summed one bit wider than the size,
  // so the largest size at the highest offset cannot wrap.
  // Does the access stay inside one aligned quadword
  function automatic logic in_qword(input logic [`MCL_ADDR_W-1:0] a, input logic [`MCL_SZ_W-1:0] sz);
    logic [`MCL_SZ_W:0] ends;
    ends = {2'h0, a[`MCL_OFS_LO-1:0]} + {1'b0, sz};
    in_qword = (ends <= {1'b0, `MCL_QW_BYTES}) && (sz != 4'h0);
  endfunction : in_qword

  // A zero size never fits, so it claims atomicity only when locked.
  // An invalid line never hits, whatever its old tag says.
  // Local lookup
  wire [`MCL_IDX_W-1:0] l_idx   = idx_of(REQ.addr);
  wire                  l_valid = (st_q[l_idx] != mcl_pkg::MCL_INV);            // R01
  wire                  l_hit   = l_valid && (tag_q[l_idx] == tag_of(REQ.addr));
  wire                  l_fits  = in_qword(REQ.addr, REQ.size);                 // R15 R16
  // Locked access that crosses a quadword holds the port for extra cycles unless it misses
  wire                  l_split = REQ.locked && !l_fits;                         // R17
  wire                  l_take  = REQ.valid && (ctl_q == MCL_IDLE) && !stale_w;

  // Probes read the array directly, never waiting for the port.
  // Probe lookup
  wire [`MCL_IDX_W-1:0] p_idx   = idx_of(PROBE.addr);
  wire                  p_hit   = PROBE.valid && (st_q[p_idx] != mcl_pkg::MCL_INV)
                                  && (tag_q[p_idx] == tag_of(PROBE.addr));
  // Dirty or owned lines are the newest copy; exclusive and shared match memory
  wire                  p_dirty = (st_q[p_idx] == mcl_pkg::MCL_MOD)
                                  || (st_q[p_idx] == mcl_pkg::MCL_OWN);         // R04 R05
  // Probe steals the line under a pending local access only when indexes differ
  wire                  p_block = (ctl_q != MCL_IDLE) && (p_idx == idx_of(req_q.addr));
  wire                  p_take  = PROBE.valid && !p_block;

  // Caching readers downgrade the line: modified turns owned so
  // this cache keeps supplying, exclusive turns shared since
  // memory is current. Non-caching readers leave it alone,
  // which saves a later upgrade.
  // Next probe state for a hit line
  mcl_pkg::mcl_state_e  p_next;
  assign p_next = PROBE.write ? mcl_pkg::MCL_INV                                 // R19 R09
                : !PROBE.will_cache ? st_q[p_idx]                                // R10
                : (st_q[p_idx] == mcl_pkg::MCL_MOD) ? mcl_pkg::MCL_OWN           // R05
                : (st_q[p_idx] == mcl_pkg::MCL_EXC) ? mcl_pkg::MCL_SHR           // R02 R03
                : st_q[p_idx];

  // Another holder is reported together with the fill strobe.
  // Fill state: shared if another cache answered, exclusive otherwise
  wire                  f_excl  = !FILL_SHARED;                                  // R02
  mcl_pkg::mcl_state_e  f_state;
  assign f_state = f_excl ? mcl_pkg::MCL_EXC : mcl_pkg::MCL_SHR;                 // R14 R03

  // Besides probes, only the held request addresses the array in miss and whit.
  // Write hit state: anything valid becomes modified
  wire [`MCL_IDX_W-1:0] h_idx   = idx_of(req_q.addr);

  // A miss outranks a split: a locked crossing access that misses
  // fetches the line and completes without the extra hold cycles.
  // Trade-off: a smaller controller, at the cost of that hold
  // for a locked crossing access that misses.
  // Control sequencing
  always_comb begin
    ctl_d = ctl_q;
    case (ctl_q)
      MCL_IDLE: begin
        if (l_take && !l_hit && REQ.cacheable) begin
          ctl_d = MCL_MISS;                                                      // R11
        end else if (l_take && l_split) begin
          ctl_d = MCL_SPLIT;                                                     // R17
        end
      end
      MCL_MISS: begin
        if (FILL_VALID) begin
          ctl_d = req_q.write ? MCL_WHIT : MCL_IDLE;                             // R14
        end
      end
      MCL_SPLIT: begin
        if (split_q == `MCL_SPLIT_CYC) begin
          ctl_d = MCL_IDLE;
        end
      end
      MCL_WHIT: begin
        ctl_d = MCL_IDLE;
      end
      default: begin
        // Unused code falls back to idle
        ctl_d = MCL_IDLE;
      end
    endcase
  end

  // Only this register leaves or enters idle.
  // Controller state register
  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      ctl_q <= MCL_IDLE;
    end else begin
      ctl_q <= ctl_d;
    end
  end

  // The request is captured on the take edge, so the caller may
  // change it after REQ_DONE without disturbing a pending fill.
  // Held request and split counter
  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      req_q   <= '0;
      split_q <= 2'h0;
    end else begin
      if (l_take) begin
        req_q <= REQ;
      end
      split_q <= (ctl_q == MCL_SPLIT) ? split_q + 2'h1 : 2'h0;
    end
  end

  // Later branches win on one index: a fill or the write after
  // it is the newest event for the held line.
  // Line array: probes, local hits, fills and the second half of a write miss.
  // Probe updates are blocked on the pending index, so the two never collide.
  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      for (int i = 0; i < `MCL_LINES; i++) begin
        st_q[i]  <= mcl_pkg::MCL_INV;
        tag_q[i] <= '0;
        dat_q[i] <= '0;
      end
    end else begin
      if (p_take && p_hit) begin
        st_q[p_idx] <= p_next;                                                   // R19
      end
      if (l_take && l_hit && REQ.write) begin
        st_q[l_idx]  <= mcl_pkg::MCL_MOD;                                        // R13
        dat_q[l_idx] <= REQ.wdata;                                               // R15
      end
      if ((ctl_q == MCL_MISS) && FILL_VALID) begin
        st_q[h_idx]  <= f_state;                                                 // R14
        tag_q[h_idx] <= tag_of(req_q.addr);
        dat_q[h_idx] <= FILL_DATA;
      end
      if (ctl_q == MCL_WHIT) begin
        st_q[h_idx]  <= mcl_pkg::MCL_MOD;                                        // R13 R14
        dat_q[h_idx] <= req_q.wdata;
      end
    end
  end

  // Clean lines answer hit without data; memory supplies then.
  // Probe answer: data only when this cache holds the newest copy
  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      prsp_q <= '0;
    end else begin
      prsp_q.done   <= p_take;
      prsp_q.hit    <= p_take && p_hit;
      prsp_q.supply <= p_take && p_hit && p_dirty;                               // R07
      prsp_q.data   <= (p_take && p_hit && p_dirty) ? dat_q[p_idx] : '0;         // R07
    end
  end

  // The miss carries the access kind so the far side can fetch
  // the line for ownership on a write.
  // Miss request stands from the taken miss until the fill arrives
  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      miss_q <= '0;
    end else if (ctl_q == MCL_IDLE && ctl_d == MCL_MISS) begin
      miss_q.valid <= 1'b1;                                                      // R11
      miss_q.write <= REQ.write;                                                 // R09
      miss_q.addr  <= REQ.addr;
    end else if (FILL_VALID) begin
      miss_q <= '0;
    end
  end

  // REQ_DONE pulses once; REQ_ATOMIC holds until the next taken request,
  // REQ_RDATA until the next read hit or fill replaces it.
  // Local completion; read hits leave state alone, data whole in one cycle
  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      req_done_q   <= 1'b0;
      req_atomic_q <= 1'b0;
      rdata_q      <= '0;
    end else begin
      req_done_q   <= (l_take && (l_hit || !REQ.cacheable) && !l_split)
                      || (ctl_q == MCL_SPLIT && ctl_d == MCL_IDLE)
                      || (ctl_q == MCL_MISS && FILL_VALID && !req_q.write)
                      || (ctl_q == MCL_WHIT);
      req_atomic_q <= l_take ? (l_fits || REQ.locked) : req_atomic_q;            // R15 R16 R17
      if (l_take && l_hit && !REQ.write) begin
        rdata_q <= dat_q[l_idx];                                                 // R12
      end else if (ctl_q == MCL_MISS && FILL_VALID) begin
        rdata_q <= FILL_DATA;
      end
    end
  end

  // REQ_READY lags the stale flag by a cycle, so it is no take
  // strobe; holding valid until done is the safe pattern.
  // LINE_STATE follows the held line while busy and the request
  // line when idle, one cycle behind the array.
  // Port ready and visible line state
  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      REQ_READY <= 1'b0;
      line_q    <= mcl_pkg::MCL_INV;
    end else begin
      REQ_READY <= (ctl_d == MCL_IDLE) && !stale_w;                              // R18
      line_q    <= st_q[(ctl_q == MCL_IDLE) ? l_idx : h_idx];
    end
  end

  // Only new requests stall; an access in flight finishes on the
  // translation it was issued under.
  // Translation refresh tracker blocks new accesses until the walk completes
  mcl_xlate_ctl u_xlate (
    .clk                         (REF_CLK),
    .nrst                        (NRST),
    .page_invalidate_instruction (PAGE_INVALIDATE),
    .page_table_base_register_wr (PAGE_BASE_WR),
    .walk_done                   (WALK_DONE),
    .stale_q                     (stale_w)
  );

  // Every output below comes straight from a flip-flop.
  // Registered outputs
  assign REQ_DONE    = req_done_q;
  assign REQ_ATOMIC  = req_atomic_q;
  assign REQ_RDATA   = rdata_q;
  assign PROBE_RSP   = prsp_q;
  assign MISS        = miss_q;
  assign XLATE_STALE = stale_w;
  assign LINE_STATE  = line_q;

endmodule : mcl_line_coh
`default_nettype wire

// *** logic/mcl_params.svh ***
// Named constants for the line coherency block: state codes, field widths, timing.
// Assumes inclusion by bare name from the block's package and modules.
`ifndef MCL_PARAMS_SVH
`define MCL_PARAMS_SVH
`define MCL_LINES        16
`define MCL_IDX_W        4
`define MCL_TAG_W        20
`define MCL_DATA_W       64
`define MCL_ADDR_W       32
`define MCL_OFS_LO       3
`define MCL_IDX_LO       3
`define MCL_TAG_LO       7
`define MCL_QW_BYTES     4'h8
`define MCL_SZ_W         4
`define MCL_ST_I         3'h0
`define MCL_ST_S         3'h1
`define MCL_ST_E         3'h2
`define MCL_ST_O         3'h3
`define MCL_ST_M         3'h4
`define MCL_SPLIT_CYC    2'h2
`endif

// *** logic/mcl_pkg.sv ***
// Types for the line coherency block: line state, request and answer carriers.
// Assumes mcl_params.svh sits beside it.
`default_nettype none
`include "mcl_params.svh"
package mcl_pkg;
  // Five coherency states with written-out codes
  typedef enum logic [2:0] {
    MCL_INV = 3'h0,
    MCL_SHR = 3'h1,
    MCL_EXC = 3'h2,
    MCL_OWN = 3'h3,
    MCL_MOD = 3'h4
  } mcl_state_e;
  // Local load or store request
  typedef struct packed {
    logic                      valid;
    logic                      write;
    logic                      locked;
    logic                      cacheable;
    logic [`MCL_SZ_W-1:0]      size;
    logic [`MCL_ADDR_W-1:0]    addr;
    logic [`MCL_DATA_W-1:0]    wdata;
  } mcl_req_s;
  // Incoming probe from another master
  typedef struct packed {
    logic                      valid;
    logic                      write;
    logic                      will_cache;
    logic [`MCL_ADDR_W-1:0]    addr;
  } mcl_probe_s;
  // Probe answer
  typedef struct packed {
    logic                      done;
    logic                      hit;
    logic                      supply;
    logic [`MCL_DATA_W-1:0]    data;
  } mcl_presp_s;
  // Outgoing miss: probe others then read memory
  typedef struct packed {
    logic                      valid;
    logic                      write;
    logic [`MCL_ADDR_W-1:0]    addr;
  } mcl_miss_s;
endpackage : mcl_pkg
`default_nettype wire

// *** logic/mcl_xlate_ctl.sv ***
// Translation refresh tracker: a page invalidate or base-register write
// marks cached translations stale so later fetches and accesses re-walk.
// Assumes one clock, asynchronous active-low reset.
`timescale 1ns/10ps
`default_nettype none
module mcl_xlate_ctl (
  // Clock and reset
  input  wire logic clk,
  input  wire logic nrst,
  // Translation events
  input  wire logic page_invalidate_instruction,
  input  wire logic page_table_base_register_wr,
  input  wire logic walk_done,
  // Status
  output logic      stale_q
);
  // Set wins over the completing walk so a late invalidate is never lost
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      stale_q <= 1'b0;
    end else if (page_invalidate_instruction || page_table_base_register_wr) begin
      stale_q <= 1'b1; // R18
    end else if (walk_done) begin
      stale_q <= 1'b0;
    end
  end
endmodule : mcl_xlate_ctl
`default_nettype wire

// *** verif/mcl_line_coh_asserts.sv ***
// Checker for the line coherency block, bound to its top module.
// Assumes mcl_pkg is compiled first; sees only the block's ports.
`timescale 1ns/10ps
`default_nettype none
module mcl_line_coh_chk (
  // Clock and reset
  input wire logic                REF_CLK,
  input wire logic                NRST,
  // Local request
  input wire mcl_pkg::mcl_req_s   REQ,
  input wire logic                REQ_READY,
  input wire logic                REQ_DONE,
  // Probe and miss
  input wire mcl_pkg::mcl_probe_s PROBE,
  input wire mcl_pkg::mcl_presp_s PROBE_RSP,
  input wire mcl_pkg::mcl_miss_s  MISS,
  input wire logic                FILL_VALID,
  // Translation refresh
  input wire logic                PAGE_INVALIDATE,
  input wire logic                PAGE_BASE_WR,
  input wire logic                WALK_DONE,
  input wire logic                XLATE_STALE
);
  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (!NRST);
  // Idle block answers every probe on the next cycle
  a_probe_done: assert property (PROBE.valid && REQ_READY && !MISS.valid && !REQ.valid |=> PROBE_RSP.done)
    else $error("probe left unanswered");
  // Data is only supplied on a hit
  a_supply_hit: assert property (PROBE_RSP.supply |-> PROBE_RSP.done && PROBE_RSP.hit)
    else $error("supply without hit");
  // A miss names the address and kind that were taken
  a_miss_start: assert property ($rose(MISS.valid) |-> MISS.addr == $past(REQ.addr) && MISS.write == $past(REQ.write))
    else $error("miss does not match request");
  // Read miss completes the cycle after the fill
  a_read_fill: assert property (MISS.valid && !MISS.write && FILL_VALID |=> REQ_DONE)
    else $error("read fill not completed");
  // Write miss fills first, then modifies
  a_write_fill: assert property (MISS.valid && MISS.write && FILL_VALID |-> ##2 REQ_DONE)
    else $error("write fill not completed");
  // Invalidate or base write marks translations stale
  a_stale_set: assert property (PAGE_INVALIDATE || PAGE_BASE_WR |=> XLATE_STALE)
    else $error("stale flag not set");
  // A finished walk clears the flag unless a new event arrives
  a_stale_clear: assert property (WALK_DONE && !PAGE_INVALIDATE && !PAGE_BASE_WR |=> !XLATE_STALE)
    else $error("stale flag not cleared");
  // No request may be taken on a stale translation
  a_stale_blocks: assert property (XLATE_STALE [*2] |-> !REQ_READY)
    else $error("ready while stale");
  c_write_fill: cover property (MISS.valid && MISS.write && FILL_VALID);
  c_supply: cover property (PROBE_RSP.supply);
  c_walk: cover property (XLATE_STALE && WALK_DONE);
endmodule : mcl_line_coh_chk
bind mcl_line_coh mcl_line_coh_chk i_chk (.REF_CLK(REF_CLK), .NRST(NRST), .REQ(REQ), .REQ_READY(REQ_READY),
  .REQ_DONE(REQ_DONE), .PROBE(PROBE), .PROBE_RSP(PROBE_RSP), .MISS(MISS), .FILL_VALID(FILL_VALID),
  .PAGE_INVALIDATE(PAGE_INVALIDATE), .PAGE_BASE_WR(PAGE_BASE_WR), .WALK_DONE(WALK_DONE), .XLATE_STALE(XLATE_STALE));
`default_nettype wire

// *** verif/mcl_fill_model.sv ***
// Far side: other caches and main memory answering the block's misses.
// Assumes MISS holds until the fill strobe.
`timescale 1ns/10ps
`default_nettype none
module mcl_fill_model (
  // Clock and reset
  input  wire logic               clk,
  input  wire logic               nrst,
  // Behaviour chosen by the bench
  input  wire logic               slow,
  input  wire logic               shared,
  // Miss in, fill out
  input  wire mcl_pkg::mcl_miss_s miss,
  output logic                    fill_valid,
  output logic                    fill_shared,
  output logic [63:0]             fill_data
);
  logic [2:0] cnt_q;  // Wait before the fill
  logic       sent_q; // One fill per miss
  // Memory supplies the word; between fills the data lines churn
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt_q      <= 3'h0;
      sent_q     <= 1'b0;
      fill_valid <= 1'b0;
      fill_data  <= 64'h0;
    end else begin
      fill_valid <= 1'b0;
      fill_data  <= ~fill_data;
      if (!miss.valid) begin
        cnt_q  <= 3'h0;
        sent_q <= 1'b0;
      end else if (!sent_q && cnt_q >= (slow ? 3'h5 : 3'h0)) begin
        fill_valid <= 1'b1;
        fill_data  <= {miss.addr, ~miss.addr};
        sent_q     <= 1'b1;
      end else begin
        cnt_q <= cnt_q + 3'h1;
      end
    end
  end
  // Another holder is reported only with the fill
  assign fill_shared = fill_valid & shared;
endmodule : mcl_fill_model
`default_nettype wire

// *** verif/moesi_cache_line_coherency_test.sv ***
// Self-checking bench for the line coherency block with its memory model.
// Assumes package, block, model and checker are compiled before it.
`timescale 1ns/10ps
`default_nettype none
module moesi_cache_line_coherency_test;
  localparam logic [31:0] A_AD = 32'h0000_1008; // Index 1
  localparam logic [31:0] B_AD = 32'h0000_2010; // Index 2
  localparam logic [31:0] C_AD = 32'h0000_3018; // Index 3
  localparam logic [63:0] W1   = 64'h1111_2222_3333_4444;
  localparam logic [63:0] W2   = 64'h5A5A_A5A5_0F0F_F0F0;
  logic                clk, nrst, slow, shared, page_inv, base_wr, walk_done;
  logic                req_ready, req_done, req_atomic, xlate_stale, fill_valid, fill_shared;
  logic [63:0]         req_rdata, fill_data;
  mcl_pkg::mcl_req_s   req;
  mcl_pkg::mcl_probe_s probe;
  mcl_pkg::mcl_presp_s rsp;
  mcl_pkg::mcl_miss_s  miss;
  mcl_pkg::mcl_state_e line_state;
  int                  miscompares = 0;
  int                  tests_run = 0;
  mcl_line_coh i_dut (.REF_CLK(clk), .NRST(nrst), .REQ(req), .REQ_READY(req_ready), .REQ_DONE(req_done),
    .REQ_ATOMIC(req_atomic), .REQ_RDATA(req_rdata), .PROBE(probe), .PROBE_RSP(rsp), .MISS(miss),
    .FILL_VALID(fill_valid), .FILL_SHARED(fill_shared), .FILL_DATA(fill_data), .PAGE_INVALIDATE(page_inv),
    .PAGE_BASE_WR(base_wr), .WALK_DONE(walk_done), .XLATE_STALE(xlate_stale), .LINE_STATE(line_state));
  mcl_fill_model i_mem (.clk(clk), .nrst(nrst), .slow(slow), .shared(shared), .miss(miss),
    .fill_valid(fill_valid), .fill_shared(fill_shared), .fill_data(fill_data));
  task automatic chk(input string name, input logic [63:0] seen, input logic [63:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  task automatic go(input logic w, input logic lk, input logic c, input logic [3:0] sz, input logic [31:0] a,
                    input logic [63:0] wd);
    @(posedge clk);
    @(posedge clk);
    req <= '{1'b1, w, lk, c, sz, a, wd};
  endtask : go
  // Valid drops in the done cycle so the idle block cannot take it twice
  task automatic fin(output int n);
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (req_done !== 1'b1 && n < 40);
    req.valid <= 1'b0;
    chk("req_done", req_done, 1'b1);
  endtask : fin
  task automatic acc(input logic w, input logic [31:0] a, input logic [63:0] wd, input mcl_pkg::mcl_state_e es);
    int n;
    go(w, 1'b0, 1'b1, 4'h8, a, wd);
    fin(n);
    @(posedge clk);
    #1;
    chk("line_state", 64'(line_state), 64'(es));
  endtask : acc
  task automatic prb(input logic w, input logic c, input logic [31:0] a, input logic [2:0] er,
                     input mcl_pkg::mcl_state_e es);
    @(posedge clk);
    probe <= '{1'b1, w, c, a};
    @(posedge clk);
    probe.valid <= 1'b0;
    #1;
    chk("probe_rsp", 64'({rsp.done, rsp.hit, rsp.supply}), 64'(er));
    if (er[0]) chk("probe_data", rsp.data, W2);
    @(posedge clk);
    #1;
    chk("probe_state", 64'(line_state), 64'(es));
  endtask : prb
  task automatic atm(input logic lk, input logic c, input logic [3:0] sz, input logic [2:0] ofs,
                     input logic ea, input int en);
    int n;
    go(1'b0, lk, c, sz, B_AD + 32'(ofs), 64'h0);
    fin(n);
    chk("req_atomic", req_atomic, ea);
    chk("latency", 64'(n), 64'(en));
  endtask : atm
  // Slow read miss, then hits and writes on the same line
  task automatic t_local;
    slow <= 1'b1;
    acc(1'b0, A_AD, 64'h0, mcl_pkg::MCL_EXC);
    chk("fill_data", req_rdata, {A_AD, ~A_AD});
    acc(1'b0, A_AD, 64'h0, mcl_pkg::MCL_EXC);
    prb(1'b0, 1'b1, A_AD, 3'h6, mcl_pkg::MCL_SHR);
    acc(1'b1, A_AD, W1, mcl_pkg::MCL_MOD);
    acc(1'b1, A_AD, W2, mcl_pkg::MCL_MOD);
    acc(1'b0, A_AD, 64'h0, mcl_pkg::MCL_MOD);
    chk("hit_data", req_rdata, W2);
  endtask : t_local
  // Caching read probe against the modified line, non-caching read and write probes against the owned line, then a probe that misses
  task automatic t_probe;
    prb(1'b0, 1'b1, A_AD, 3'h7, mcl_pkg::MCL_OWN);
    prb(1'b0, 1'b0, A_AD, 3'h7, mcl_pkg::MCL_OWN);
    prb(1'b1, 1'b1, A_AD, 3'h7, mcl_pkg::MCL_INV);
    prb(1'b0, 1'b1, A_AD, 3'h4, mcl_pkg::MCL_INV);
  endtask : t_probe
  // Prompt write miss and shared read miss
  task automatic t_miss;
    slow <= 1'b0;
    acc(1'b1, B_AD, W1, mcl_pkg::MCL_MOD);
    acc(1'b0, B_AD, 64'h0, mcl_pkg::MCL_MOD);
    chk("wmiss_data", req_rdata, W1);
    shared <= 1'b1;
    acc(1'b0, C_AD, 64'h0, mcl_pkg::MCL_SHR);
    shared <= 1'b0;
    prb(1'b0, 1'b1, C_AD, 3'h6, mcl_pkg::MCL_SHR);
    acc(1'b1, C_AD, W2, mcl_pkg::MCL_MOD);
  endtask : t_miss
  // Stale translation holds a request back until the walk ends
  task automatic t_stale(input logic base);
    int n;
    @(posedge clk);
    page_inv <= ~base;
    base_wr <= base;
    @(posedge clk);
    page_inv <= 1'b0;
    base_wr <= 1'b0;
    req <= '{1'b1, 1'b0, 1'b0, 1'b1, 4'h8, B_AD, 64'h0};
    repeat (6) @(posedge clk);
    #1;
    chk("blocked", req_done, 1'b0);
    chk("stale", xlate_stale, 1'b1);
    chk("ready", req_ready, 1'b0);
    @(posedge clk);
    walk_done <= 1'b1;
    @(posedge clk);
    walk_done <= 1'b0;
    fin(n);
    chk("after_walk", req_rdata, W1);
  endtask : t_stale
  task automatic end_sim;
    if (miscompares == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : end_sim
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    nrst = 1'b0;
    {slow, shared, page_inv, base_wr, walk_done} = 5'h00;
    req = '0;
    probe = '0;
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    t_local();
    t_probe();
    t_miss();
    atm(1'b0, 1'b1, 4'h8, 3'h0, 1'b1, 1);
    atm(1'b0, 1'b1, 4'h2, 3'h5, 1'b1, 1);
    atm(1'b0, 1'b0, 4'h4, 3'h6, 1'b0, 1);
    atm(1'b1, 1'b0, 4'h4, 3'h6, 1'b1, 4);
    t_stale(1'b0);
    t_stale(1'b1);
    end_sim();
  end
  // Watchdog far beyond the hundred-odd cycles the tests take
  initial begin
    #50000;
    miscompares++;
    end_sim();
  end
endmodule : moesi_cache_line_coherency_test
`default_nettype wire
